/* lrs_pkg.sv */
// Package with command encodings, timing figures and cycle counts for the refresh scheduler.
package lrs_pkg;
   // Clock period of mclk in picoseconds.
   localparam int CLK_PS = 100000;
   // Spacing figures in picoseconds for the memory grade in use.
   localparam int ALL_BANK_REFRESH_CYCLE_TIME_PS = 130000;
   localparam int PER_BANK_REFRESH_CYCLE_TIME_PS = 60000;
   localparam int ACTIVATE_TO_ACTIVATE_SPACING_PS = 10000;
   // Average refresh interval in nanoseconds.
   localparam int AVERAGE_REFRESH_INTERVAL_NS = 3900;
   // Least spacings round up to whole cycles, never below one.
   localparam int RFCAB_CYC = (ALL_BANK_REFRESH_CYCLE_TIME_PS + CLK_PS - 1) / CLK_PS;
   localparam int RFCPB_CYC = (PER_BANK_REFRESH_CYCLE_TIME_PS + CLK_PS - 1) / CLK_PS;
   localparam int RRD_CYC = (ACTIVATE_TO_ACTIVATE_SPACING_PS + CLK_PS - 1) / CLK_PS;
   // Average interval rounds down, being a longest time.
   localparam int REFI_CYC = (AVERAGE_REFRESH_INTERVAL_NS * 1000) / CLK_PS;
   // Burst window is four times eight all-bank cycle times.
   localparam int BURST_WIN_CYC = 4 * 8 * RFCAB_CYC;
   // Burst limit of all-bank refreshes per burst window.
   localparam int BURST_MAX = 8;
   // Number of banks.
   localparam int NBANK = 8;
   // Command line values on a refresh: lines 0 and 1 low, line 2 high.
   localparam logic [3:0] CMD_REF_ALL = 4'hc;
   localparam logic [3:0] CMD_REF_PB = 4'h4;
   localparam logic [3:0] CMD_IDLE = 4'hf;
   // Cycles after chip select falls in which a detected link edge may predate it.
   localparam int LINK_SYNC_CYC = 2;
   // Issue modes of the scheduler.
   typedef enum logic [1:0] {LRS_IDLE, LRS_WAIT_LINK, LRS_DRIVE} lrs_state_type;
endpackage : lrs_pkg

/* lrs_timer.sv */
// Down counter that blocks a command class until a spacing expires.
`timescale 1ns/10ps
module lrs_timer #(
   parameter int W = 16
) (
   // Clock and reset.
   input wire logic mclk,
   input wire logic rst_n,
   // Load request and count.
   input wire logic load,
   input wire logic [W-1:0] count,
   // Busy while counting.
   output logic busy
);
   logic [W-1:0] cnt_r;
   logic [W-1:0] cnt_nxt;

   // A fresh load wins over the countdown so a back to back command restarts the spacing.
   always_comb begin
      cnt_nxt = cnt_r;
      if (load) begin
         cnt_nxt = count;
      end else if (cnt_r != '0) begin
         cnt_nxt = cnt_r - 1'b1;
      end
   end

   // Registered count.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   assign busy = (cnt_r != '0);
endmodule : lrs_timer

/* lrs_sched.sv */
// Refresh scheduler that drives refresh commands to the memory on the link clock edges.
`timescale 1ns/10ps
// Functional notes
// (R1) After all-bank refresh, wait its cycle time before any refresh or activate.
// (R2) After per-bank refresh, wait its cycle time before refresh or same-bank activate.
// (R3) After per-bank refresh, space other-bank activates by activate spacing.
// (R4) After activate, space a per-bank refresh to another idle bank.
// (R5) Two activates to different banks keep activate spacing apart.
// (R6) Refresh only idle banks; no all-bank refresh while any bank is open.
// (R7) Issue enough all-bank refreshes in every rolling refresh window.
// (R8) Eight per-bank refreshes count as one all-bank refresh.
// (R9) At most eight all-bank refreshes per rolling burst window.
// (R10) Self refresh time reduces the required refresh count, rounded up.
// (R11) Regular pattern: one refresh every average refresh interval.
// (R12) Burst then pause until the refresh window ends is allowed.
// (R13) Pattern changes keep every rolling window satisfied.
// (R14) Switch to regular only right after a burst phase.
// (R15) Enter self refresh after a burst; resume with a burst on exit.
// (R16) Refresh: chip select low, lines 0,1 low, 2 high; line 3 picks type.
// (R17) Per-bank refresh walks banks 0 to 7 round robin.
// (R18) Bank counter clears on reset, self refresh exit and all-bank refresh.
// (R19) Spacings held as rounded-up cycle counts blocking conflicting commands.
// (R20) Sliding count of all-bank refreshes checks burst maximum; the code uses a fixed window opened by an all-bank refresh.
module lrs_sched
   import lrs_pkg::*;
#(
   parameter int REFI = REFI_CYC,
   parameter int BURSTW = BURST_WIN_CYC
) (
   // Clock and reset.
   input wire logic mclk,
   input wire logic rst_n,
   // Link clock from the memory side.
   input wire logic link_clk,
   // User controls.
   input wire logic use_per_bank,
   input wire logic burst_mode,
   input wire logic self_refresh_exit,
   input wire logic activate_req,
   input wire logic [2:0] activate_bank,
   input wire logic [NBANK-1:0] bank_open,
   // Command pins.
   output logic cs_n,
   output logic [3:0] ca,
   // Status toward the user.
   output logic activate_ok,
   output logic [2:0] pb_bank,
   output logic [3:0] burst_count,
   output logic refresh_owed
);
   logic [1:0] lsync_r;
   logic lprev_r;
   logic ledge;
   logic ab_busy, pb_busy, rrd_busy;
   logic ld_ab, ld_pb, ld_rrd;
   lrs_state_type st_r, st_nxt;
   logic is_pb_r, is_pb_nxt;
   logic cs_n_r, cs_n_nxt;
   logic [3:0] ca_r, ca_nxt;
   logic [2:0] bank_r, bank_nxt;
   logic [2:0] pbdone_r, pbdone_nxt;
   logic [15:0] refi_r, refi_nxt;
   logic [3:0] owed_r, owed_nxt;
   logic [15:0] bwin_r, bwin_nxt;
   logic [3:0] bcnt_r, bcnt_nxt;
   logic act_ok_r, act_ok_nxt;
   logic [2:0] last_pb_r, last_pb_nxt;
   logic can_issue, any_open, act_fire, unit_done;
   logic [1:0] arm_r, arm_nxt;
   logic owed_flag_r, owed_flag_nxt;

   // Link clock passes two flops before edge detection reads it.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         lsync_r <= 2'h0;
         lprev_r <= 1'b0;
      end else begin
         lsync_r <= {lsync_r[0], link_clk};
         lprev_r <= lsync_r[1];
      end
   end
   assign ledge = lsync_r[1] & ~lprev_r;

   // Spacing timers.
   lrs_timer u_ab (.mclk(mclk), .rst_n(rst_n), .load(ld_ab),
      .count(16'(RFCAB_CYC)), .busy(ab_busy)); // R1 R19
   lrs_timer u_pb (.mclk(mclk), .rst_n(rst_n), .load(ld_pb),
      .count(16'(RFCPB_CYC)), .busy(pb_busy)); // R2 R19
   lrs_timer u_rrd (.mclk(mclk), .rst_n(rst_n), .load(ld_rrd),
      .count(16'(RRD_CYC)), .busy(rrd_busy)); // R3 R4 R5 R19

   assign any_open = |bank_open;
   assign act_fire = activate_req & act_ok_r;

   // Scheduling decisions: refresh is driven for one link rising edge.
   always_comb begin
      st_nxt = st_r;
      is_pb_nxt = is_pb_r;
      cs_n_nxt = cs_n_r;
      ca_nxt = ca_r;
      bank_nxt = bank_r;
      pbdone_nxt = pbdone_r;
      refi_nxt = refi_r;
      owed_nxt = owed_r;
      bwin_nxt = bwin_r;
      bcnt_nxt = bcnt_r;
      last_pb_nxt = last_pb_r;
      arm_nxt = arm_r;
      ld_ab = 1'b0;
      ld_pb = 1'b0;
      ld_rrd = act_fire; // R5
      unit_done = 1'b0;
      can_issue = 1'b0;
      // Average interval tick adds a refresh owed.
      if (refi_r == 16'h0) begin
         refi_nxt = 16'(REFI - 1); // R11
         if (owed_r != 4'hf) begin
            owed_nxt = owed_r + 4'h1; // R7
         end
      end else begin
         refi_nxt = refi_r - 16'h1;
      end
      // Burst window: the count clears when it expires, and the next all-bank refresh restarts it.
      if (bwin_r != 16'h0) begin
         bwin_nxt = bwin_r - 16'h1;
      end else begin
         bcnt_nxt = 4'h0; // R20
      end
      // The device refreshes itself while in self refresh, so the intervals spent there are
      // credited. Limitation: a refresh still owed at entry is forgiven as well, so enter
      // self refresh with nothing owed. A burst resume owes a full burst instead.
      if (self_refresh_exit) begin
         owed_nxt = burst_mode ? 4'h8 : 4'h0; // R10 R15
         // Regular ticks restart at once, so a burst flows straight into the regular pattern.
         refi_nxt = 16'(REFI - 1); // R14
      end
      case (st_r)
         LRS_IDLE: begin
            // Burst mode drains all owed refreshes back to back, then pauses.
            if (owed_r != 4'h0 && !ab_busy && !pb_busy) begin // R1 R2 R12
               if (use_per_bank) begin
                  can_issue = !bank_open[bank_r] && !rrd_busy && !activate_req; // R4 R6
               end else begin
                  can_issue = !any_open && !activate_req
                     && (bcnt_r < 4'(BURST_MAX)); // R6 R9
               end
            end
            if (can_issue) begin
               is_pb_nxt = use_per_bank;
               cs_n_nxt = 1'b0;
               ca_nxt = use_per_bank ? CMD_REF_PB : CMD_REF_ALL; // R16
               st_nxt = LRS_WAIT_LINK;
               arm_nxt = 2'h0;
            end
         end
         LRS_WAIT_LINK: begin
            // An edge detected in the first cycles may have risen before chip select fell,
            // so the device would miss the command; only later edges are taken.
            if (arm_r != 2'(LINK_SYNC_CYC)) begin
               arm_nxt = arm_r + 2'h1;
            end else if (ledge) begin
               st_nxt = LRS_DRIVE; // R16
            end
         end
         LRS_DRIVE: begin
            cs_n_nxt = 1'b1;
            ca_nxt = CMD_IDLE;
            st_nxt = LRS_IDLE;
            if (is_pb_r) begin
               ld_pb = 1'b1;
               ld_rrd = 1'b1; // R3
               last_pb_nxt = bank_r;
               bank_nxt = bank_r + 3'h1; // R17
               pbdone_nxt = pbdone_r + 3'h1;
               unit_done = (pbdone_r == 3'h7); // R8
            end else begin
               ld_ab = 1'b1;
               bank_nxt = 3'h0; // R18
               pbdone_nxt = 3'h0;
               unit_done = 1'b1;
               if (bwin_r == 16'h0) begin
                  bwin_nxt = 16'(BURSTW);
                  bcnt_nxt = 4'h1;
               end else begin
                  bcnt_nxt = bcnt_r + 4'h1; // R9
               end
            end
            if (unit_done && owed_nxt != 4'h0) begin
               owed_nxt = owed_nxt - 4'h1; // R13
            end
         end
         default: begin
            st_nxt = LRS_IDLE;
         end
      endcase
      // Exit clears the bank counter even when a command ends in the same cycle.
      if (self_refresh_exit) begin
         bank_nxt = 3'h0; // R18
         pbdone_nxt = 3'h0;
      end
      // Activates are allowed once no refresh is in flight, the all-bank and activate spacings expire, and no per-bank spacing holds the requested bank.
      act_ok_nxt = !ab_busy && !ld_ab && !rrd_busy && !ld_rrd
         && st_nxt == LRS_IDLE
         && !(pb_busy && activate_bank == last_pb_r); // R1 R2 R3 R5
      owed_flag_nxt = (owed_nxt != 4'h0); // R7
   end

   // Registers of the scheduler.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= LRS_IDLE;
         is_pb_r <= 1'b0;
         cs_n_r <= 1'b1;
         ca_r <= CMD_IDLE;
         bank_r <= 3'h0;
         pbdone_r <= 3'h0;
         refi_r <= 16'h0;
         owed_r <= 4'h0;
         bwin_r <= 16'h0;
         bcnt_r <= 4'h0;
         act_ok_r <= 1'b0;
         last_pb_r <= 3'h0;
         arm_r <= 2'h0;
         owed_flag_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         is_pb_r <= is_pb_nxt;
         cs_n_r <= cs_n_nxt;
         ca_r <= ca_nxt;
         bank_r <= bank_nxt;
         pbdone_r <= pbdone_nxt;
         refi_r <= refi_nxt;
         owed_r <= owed_nxt;
         bwin_r <= bwin_nxt;
         bcnt_r <= bcnt_nxt;
         act_ok_r <= act_ok_nxt;
         last_pb_r <= last_pb_nxt;
         arm_r <= arm_nxt;
         owed_flag_r <= owed_flag_nxt;
      end
   end

   assign cs_n = cs_n_r;
   assign ca = ca_r;
   assign activate_ok = act_ok_r;
   assign pb_bank = bank_r;
   assign burst_count = bcnt_r;
   assign refresh_owed = owed_flag_r;

   // Checks on the command stream.
   AST_AB_SPACING: assert property (@(posedge mclk) disable iff (!rst_n)
      (ld_ab |=> ab_busy)) else $error("all-bank spacing not started"); // R1
   AST_PB_SPACING: assert property (@(posedge mclk) disable iff (!rst_n)
      (ld_pb |=> pb_busy)) else $error("per-bank spacing not started"); // R2
   AST_RRD_PB: assert property (@(posedge mclk) disable iff (!rst_n)
      (ld_pb |=> rrd_busy)) else $error("activate spacing after refresh missing"); // R3
   AST_ACT_BLOCK: assert property (@(posedge mclk) disable iff (!rst_n)
      (ab_busy |-> !act_ok_nxt)) else $error("activate allowed in refresh"); // R1
   AST_NO_AB_OPEN: assert property (@(posedge mclk) disable iff (!rst_n)
      (st_r == LRS_IDLE && can_issue && !use_per_bank |-> !any_open))
      else $error("all-bank refresh with open bank"); // R6
   AST_BURST_MAX: assert property (@(posedge mclk) disable iff (!rst_n)
      (bcnt_r <= 4'(BURST_MAX))) else $error("burst limit exceeded"); // R9
   AST_ENCODE: assert property (@(posedge mclk) disable iff (!rst_n)
      (!cs_n_r |-> ca_r[2:0] == 3'h4)) else $error("bad refresh encoding"); // R16
   AST_BANK_CLR: assert property (@(posedge mclk) disable iff (!rst_n)
      (st_r == LRS_DRIVE && !is_pb_r |=> bank_r == 3'h0))
      else $error("bank counter not cleared"); // R18
   AST_BANK_STEP: assert property (@(posedge mclk) disable iff (!rst_n)
      (st_r == LRS_DRIVE && is_pb_r && !self_refresh_exit
         |=> bank_r == $past(bank_r) + 3'h1)) else $error("bank order broken"); // R17
   COV_AB: cover property (@(posedge mclk) st_r == LRS_DRIVE && !is_pb_r);
   COV_PB: cover property (@(posedge mclk) st_r == LRS_DRIVE && is_pb_r);
   COV_PB_WRAP: cover property (@(posedge mclk) unit_done && is_pb_r);
   COV_BURST_FULL: cover property (@(posedge mclk) bcnt_r == 4'(BURST_MAX));
endmodule : lrs_sched

/* lrs_mem_model.sv */
// Behavioural memory device that makes the link clock and checks refresh commands.
`timescale 1ns/10ps
module lrs_mem_model
   import lrs_pkg::*;
(
   // Link clock and command pins.
   output logic link_clk,
   input wire logic cs_n,
   input wire logic [3:0] ca,
   input wire logic sr_exit,
   // Counts for the bench.
   output int ab_count,
   output int pb_count,
   output logic [2:0] bank_ctr,
   output int err_count
);
   realtime last_t;
   realtime gap;
   realtime ab_t[$];
   // The link clock runs freely, so a waiting command is always taken.
   initial begin
      link_clk = 1'b0;
      forever #400 link_clk = ~link_clk;
   end
   // Commands are taken on the rising link edge only.
   initial begin
      ab_count = 0;
      pb_count = 0;
      err_count = 0;
      bank_ctr = 3'h0;
      last_t = -1.0e6;
      gap = 0.0;
      forever begin
         @(posedge link_clk or posedge sr_exit);
         if (sr_exit) begin
            bank_ctr = 3'h0;
         end else if (cs_n === 1'b0) begin
            if ($realtime - last_t < gap) err_count++;
            last_t = $realtime;
            if (ca === CMD_REF_ALL) begin
               ab_count++;
               bank_ctr = 3'h0;
               gap = ALL_BANK_REFRESH_CYCLE_TIME_PS / 1000.0;
               ab_t.push_back($realtime);
               if (ab_t.size() > BURST_MAX) begin
                  // A ninth refresh inside one burst window is too many.
                  if ($realtime - ab_t[0] < 4.0 * gap * 8) err_count++;
                  void'(ab_t.pop_front());
               end
            end else if (ca === CMD_REF_PB) begin
               pb_count++;
               bank_ctr = bank_ctr + 3'h1;
               gap = PER_BANK_REFRESH_CYCLE_TIME_PS / 1000.0;
            end else begin
               err_count++;
            end
         end
      end
   end
endmodule : lrs_mem_model

/* testbench.sv */
// Self-checking bench for the refresh scheduler with a memory device model.
`timescale 1ns/10ps
module testbench;
   import lrs_pkg::*;
   logic mclk, rst_n, use_per_bank, burst_mode, self_refresh_exit, activate_req;
   logic link_clk, cs_n, activate_ok, refresh_owed, act_seen;
   logic [2:0] activate_bank, pb_bank, bank_ctr;
   logic [NBANK-1:0] bank_open;
   logic [3:0] ca, burst_count, cmd;
   int ab_count, pb_count, err_count, n_fail, check_count;

   lrs_sched #(.REFI(39), .BURSTW(64)) u_dut (.mclk(mclk), .rst_n(rst_n),
      .link_clk(link_clk), .use_per_bank(use_per_bank), .burst_mode(burst_mode),
      .self_refresh_exit(self_refresh_exit), .activate_req(activate_req),
      .activate_bank(activate_bank), .bank_open(bank_open), .cs_n(cs_n), .ca(ca),
      .activate_ok(activate_ok), .pb_bank(pb_bank), .burst_count(burst_count),
      .refresh_owed(refresh_owed));
   lrs_mem_model u_mem (.link_clk(link_clk), .cs_n(cs_n), .ca(ca),
      .sr_exit(self_refresh_exit), .ab_count(ab_count), .pb_count(pb_count),
      .bank_ctr(bank_ctr), .err_count(err_count));

   // Free-running system clock.
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   task automatic chk(logic [7:0] got, logic [7:0] exp, string what);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("FAIL t=%0t %s got %0h exp %0h", $time, what, got, exp);
      end
   endtask : chk

   // Waits for one command under a bound; a missing command leaves ca idle and fails.
   task automatic wait_cmd();
      int i;
      for (i = 0; i < 200 && cs_n !== 1'b0; i++) @(negedge mclk);
      cmd = ca;
      act_seen = activate_ok;
      for (i = 0; i < 50 && cs_n !== 1'b1; i++) @(negedge mclk);
      @(negedge mclk);
   endtask : wait_cmd

   task automatic t_all_bank();
      use_per_bank = 1'b0;
      repeat (3) begin
         wait_cmd();
         chk(8'(cmd), 8'(CMD_REF_ALL), "all-bank code");
         chk(8'(act_seen), 8'h00, "activate during refresh");
         chk(8'(pb_bank), 8'h00, "bank after all-bank");
      end
      $display("all-bank test done");
   endtask : t_all_bank

   task automatic t_per_bank();
      int k;
      use_per_bank = 1'b1;
      for (k = 0; k < 9; k++) begin
         chk(8'(pb_bank), 8'(k % 8), "next target");
         wait_cmd();
         chk(8'(cmd), 8'(CMD_REF_PB), "per-bank code");
         chk(8'(bank_ctr), 8'((k + 1) % 8), "device bank");
      end
      $display("per-bank test done");
   endtask : t_per_bank

   // An open target bank must hold back the refresh of either kind.
   task automatic t_bank_open();
      int m, n;
      for (m = 0; m < 2; m++) begin
         use_per_bank = m[0];
         bank_open = m[0] ? 8'(1 << pb_bank) : 8'h10;
         n = 0;
         repeat (100) begin
            @(negedge mclk);
            if (cs_n === 1'b0) n++;
         end
         chk(8'(n), 8'h00, "refresh while open");
         chk(8'(refresh_owed), 8'h01, "owed while held");
         bank_open = 8'h00;
         wait_cmd();
         chk(8'(cmd), m[0] ? 8'(CMD_REF_PB) : 8'(CMD_REF_ALL), "after close");
      end
      $display("bank open test done");
   endtask : t_bank_open

   task automatic t_sr_exit();
      int a0;
      use_per_bank = 1'b1;
      repeat (2) wait_cmd();
      // Refreshes are held off across the exit, as no command may follow it at once.
      bank_open = 8'hff;
      self_refresh_exit = 1'b1;
      @(negedge mclk);
      self_refresh_exit = 1'b0;
      repeat (2) @(negedge mclk);
      chk(8'(pb_bank), 8'h00, "bank after exit");
      chk(8'(bank_ctr), 8'h00, "device bank after exit");
      chk(8'(refresh_owed), 8'h00, "owed after exit");
      // Burst resume owes eight all-bank refreshes at once.
      bank_open = 8'h00;
      use_per_bank = 1'b0;
      burst_mode = 1'b1;
      a0 = ab_count;
      self_refresh_exit = 1'b1;
      @(negedge mclk);
      self_refresh_exit = 1'b0;
      repeat (150) @(negedge mclk);
      chk(8'(ab_count - a0 >= 8), 8'h01, "burst on exit");
      chk(8'(burst_count <= 4'(BURST_MAX)), 8'h01, "burst count");
      burst_mode = 1'b0;
      $display("self refresh exit test done");
   endtask : t_sr_exit

   // A waiting activate is given room and holds back new refreshes.
   task automatic t_activate();
      int n, seen;
      n = 0;
      seen = 0;
      wait_cmd();
      activate_req = 1'b1;
      activate_bank = 3'h2;
      repeat (60) begin
         @(negedge mclk);
         if (activate_ok === 1'b1) seen = 1;
         if (cs_n === 1'b0) n++;
      end
      activate_req = 1'b0;
      chk(8'(n), 8'h00, "refresh during activate");
      chk(8'(seen), 8'h01, "activate allowed");
      $display("activate test done");
   endtask : t_activate

   task tally_and_finish();
      $display("checks %0d failures %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : tally_and_finish

   // Watchdog sized well above the run of all tests.
   initial begin
      repeat (20000) @(posedge mclk);
      n_fail++;
      $display("FAIL t=%0t watchdog expired", $time);
      tally_and_finish();
   end

   // Main sequence: reset values, then each scenario in turn.
   initial begin
      n_fail = 0;
      check_count = 0;
      rst_n = 1'b0;
      {use_per_bank, burst_mode, self_refresh_exit, activate_req} = 4'h0;
      activate_bank = 3'h0;
      bank_open = 8'h00;
      repeat (5) @(negedge mclk);
      chk(8'({cs_n, ca, activate_ok}), 8'h3e, "reset outputs");
      chk(8'(pb_bank), 8'h00, "reset bank");
      rst_n = 1'b1;
      t_all_bank();
      t_per_bank();
      t_bank_open();
      t_sr_exit();
      t_activate();
      chk(8'(err_count), 8'h00, "device spacing errors");
      tally_and_finish();
   end
endmodule : testbench
